// file: tec_cfg.svh
// Register offsets, field positions, reset values and limits of the timer/event counter
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

`define TEC_ADDR_W 8
`define TEC_ADDR_LOW 8'h00
`define TEC_ADDR_HIGH 8'h04
`define TEC_ADDR_CTRL 8'h08
`define TEC_ADDR_INTERRUPT_CONTROL 8'h0c

`define TEC_CTRL_EDGE 3
`define TEC_CTRL_RUN 4
`define TEC_CTRL_MODE_LO 6
`define TEC_CTRL_MODE_HI 7
`define TEC_CTRL_RESET 8'h08

`define TEC_INTERRUPT_CONTROL_IRQ_EN 2
`define TEC_INTERRUPT_CONTROL_FLAG 5
`define TEC_INTERRUPT_CONTROL_RESET 8'h00

`define TEC_CNT_MAX 16'hffff
`define TEC_CNT_RESET 16'h0000
`define TEC_BYTE_RESET 8'h00

`endif

// file: tec_pkg.sv
// Types shared by the timer/event counter modules
package tec_pkg;

	typedef enum logic [1:0] {
		TEC_MODE_NONE = 2'h0,
		TEC_MODE_EVENT = 2'h1,
		TEC_MODE_TIMER = 2'h2,
		TEC_MODE_PULSE = 2'h3
	} tec_mode_type;

	typedef enum logic [1:0] {
		TEC_ST_WAIT = 2'b01,
		TEC_ST_MEAS = 2'b10
	} tec_state_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} tec_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tec_apb_rsp_type;

	typedef struct packed {
		logic active;
		logic ret;
	} tec_pin_ev_type;

endpackage

// file: tec_pin_edge.sv
// Edge detector for the external counter input pin
`timescale 1ns/1ns
module tec_pin_edge (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pin and edge choice
	input wire logic pin_i,
	input wire logic edge_sel_i,
	// Detected transitions
	output tec_pkg::tec_pin_ev_type ev_o
);
	import tec_pkg::*;

	logic prev_reg;
	logic prev_next;
	logic rise;
	logic fall;

	always_comb begin
		prev_next = pin_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
		end
	end

	assign rise = pin_i & ~prev_reg;
	assign fall = ~pin_i & prev_reg;

	// Zero picks rising, one picks falling, in every mode
	always_comb begin
		ev_o.active = edge_sel_i ? fall : rise;
		ev_o.ret = edge_sel_i ? rise : fall;
	end

endmodule

// file: tec_top.sv
// Timer/event counter, 16-bit, with APB register access
//
// Overview of operation
// - Event and timer modes count upward from present value to all ones.
// - Overflow reloads from preload and sets the overflow flag, bit 5, same cycle.
// - Control bits 0 to 2 and 5 read as zero.
// - Control bit 3 picks active edge: 0 rising, 1 falling.
// - Counting only while run bit 4 is one.
// - Control bits 7:6 select mode: 01 event, 10 timer, 11 pulse, 00 unused.
// - Pulse mode starts at active edge, stops at return level, clears run.
// - Finished measurement is held; one measurement per run set.
// - Pulse measurement starts on an edge, never on the level alone.
// - Overflow during pulse measurement reloads and flags like other modes.
// - Event and timer modes never clear the run bit themselves.
// - Overflow is a wake-up event ending halt.
// - Interrupt service withheld while the enable bit is zero.
// - Preload write with run clear also loads the counter.
// - Preload write with run set leaves the counter counting.
// - Reading the counter high byte blocks counting during that access.
// - Event mode counts pin edges; timer mode counts instruction clocks.
// - Pulse mode counts instruction clocks while the measured level persists.
// - Low byte write buffered; high write loads preload; high read latches low.
`timescale 1ns/1ns
`include "tec_cfg.svh"
module tec_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// APB slave
	input tec_pkg::tec_apb_req_type apb_req_i,
	output tec_pkg::tec_apb_rsp_type apb_rsp_o,
	// External counter pin
	input wire logic counter_input_pin_i,
	// Interrupt and wake-up
	output logic overflow_irq_o,
	output logic overflow_flag_o,
	output logic wake_o
);
	import tec_pkg::*;

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offs);
		addr_hit = (addr == offs);
	endfunction

	logic [15:0] count_reg, count_next;
	logic [15:0] preload_reg, preload_next;
	logic [7:0] byte_buf_reg, byte_buf_next;
	logic [31:0] prdata_reg, prdata_next;
	logic edge_select_reg, edge_select_next;
	logic count_run_reg, count_run_next;
	tec_mode_type mode_reg, mode_next;
	logic overflow_flag_reg, overflow_flag_next;
	logic irq_enable_reg, irq_enable_next;
	logic wake_reg, wake_next;
	tec_state_type state_reg, state_next;

	tec_pin_ev_type pin_ev;
	logic setup_ph, access_ph, mapped;
	logic wr_low, wr_high, wr_ctrl, wr_interrupt_control;
	logic count_block, tick, overflow, pulse_done;
	logic [15:0] wr_value;

	tec_pin_edge u_pin_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(counter_input_pin_i),
		.edge_sel_i(edge_select_reg),
		.ev_o(pin_ev)
	);

	// Bus decode
	assign setup_ph = apb_req_i.psel & ~apb_req_i.penable;
	assign access_ph = apb_req_i.psel & apb_req_i.penable;
	assign mapped = addr_hit(apb_req_i.paddr, `TEC_ADDR_LOW)
		| addr_hit(apb_req_i.paddr, `TEC_ADDR_HIGH)
		| addr_hit(apb_req_i.paddr, `TEC_ADDR_CTRL)
		| addr_hit(apb_req_i.paddr, `TEC_ADDR_INTERRUPT_CONTROL);
	assign wr_low = access_ph & apb_req_i.pwrite & addr_hit(apb_req_i.paddr, `TEC_ADDR_LOW);
	assign wr_high = access_ph & apb_req_i.pwrite & addr_hit(apb_req_i.paddr, `TEC_ADDR_HIGH);
	assign wr_ctrl = access_ph & apb_req_i.pwrite & addr_hit(apb_req_i.paddr, `TEC_ADDR_CTRL);
	assign wr_interrupt_control = access_ph & apb_req_i.pwrite & addr_hit(apb_req_i.paddr, `TEC_ADDR_INTERRUPT_CONTROL);
	assign wr_value = {apb_req_i.pwdata[7:0], byte_buf_reg};

	// Whole read of the high byte freezes the count, both phases
	assign count_block = apb_req_i.psel & ~apb_req_i.pwrite
		& addr_hit(apb_req_i.paddr, `TEC_ADDR_HIGH);

	// Count source per mode
	always_comb begin
		case (mode_reg)
			TEC_MODE_EVENT: tick = count_run_reg & pin_ev.active;
			TEC_MODE_TIMER: tick = count_run_reg;
			// Return cycle already shows the other level, so it is not counted
			TEC_MODE_PULSE: tick = count_run_reg & (state_reg == TEC_ST_MEAS) & ~pin_ev.ret;
			default: tick = 1'b0;
		endcase
		tick = tick & ~count_block;
	end

	// Overflow in any counting mode, pulse included; mode 00 never ticks
	assign overflow = tick & (count_reg == `TEC_CNT_MAX);
	assign pulse_done = (mode_reg == TEC_MODE_PULSE) & (state_reg == TEC_ST_MEAS)
		& count_run_reg & pin_ev.ret;

	// Counter, preload and byte buffer
	always_comb begin
		count_next = count_reg;
		preload_next = preload_reg;
		byte_buf_next = byte_buf_reg;
		if (tick) begin
			count_next = overflow ? preload_reg : count_reg + 16'h0001;
		end
		if (wr_high) begin
			preload_next = wr_value;
			if (!count_run_reg) begin
				count_next = wr_value;
			end
		end
		if (wr_low) begin
			byte_buf_next = apb_req_i.pwdata[7:0];
		end else if (setup_ph & count_block) begin
			// Low byte caught with the high byte so the pair is coherent
			byte_buf_next = count_reg[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= `TEC_CNT_RESET;
			preload_reg <= `TEC_CNT_RESET;
			byte_buf_reg <= `TEC_BYTE_RESET;
		end else begin
			count_reg <= count_next;
			preload_reg <= preload_next;
			byte_buf_reg <= byte_buf_next;
		end
	end

	// Control bits; software write wins over the automatic run clear
	always_comb begin
		edge_select_next = edge_select_reg;
		count_run_next = count_run_reg;
		mode_next = mode_reg;
		if (wr_ctrl) begin
			edge_select_next = apb_req_i.pwdata[`TEC_CTRL_EDGE];
			count_run_next = apb_req_i.pwdata[`TEC_CTRL_RUN];
			mode_next = tec_mode_type'(apb_req_i.pwdata[`TEC_CTRL_MODE_HI:`TEC_CTRL_MODE_LO]);
		end else if (pulse_done) begin
			count_run_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			edge_select_reg <= 1'(`TEC_CTRL_RESET >> `TEC_CTRL_EDGE);
			count_run_reg <= 1'(`TEC_CTRL_RESET >> `TEC_CTRL_RUN);
			mode_reg <= TEC_MODE_NONE;
		end else begin
			edge_select_reg <= edge_select_next;
			count_run_reg <= count_run_next;
			mode_reg <= mode_next;
		end
	end

	// Pulse measurement sequencer: armed only by an edge
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TEC_ST_WAIT: begin
				if ((mode_reg == TEC_MODE_PULSE) & count_run_reg & pin_ev.active) begin
					state_next = TEC_ST_MEAS;
				end
			end
			TEC_ST_MEAS: begin
				if (!count_run_reg || mode_reg != TEC_MODE_PULSE || pin_ev.ret) begin
					state_next = TEC_ST_WAIT;
				end
			end
			default: state_next = TEC_ST_WAIT;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= TEC_ST_WAIT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Interrupt control: a new overflow beats a clearing write
	always_comb begin
		irq_enable_next = wr_interrupt_control ? apb_req_i.pwdata[`TEC_INTERRUPT_CONTROL_IRQ_EN] : irq_enable_reg;
		overflow_flag_next = wr_interrupt_control ? apb_req_i.pwdata[`TEC_INTERRUPT_CONTROL_FLAG] : overflow_flag_reg;
		overflow_flag_next = overflow_flag_next | overflow;
		wake_next = overflow;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_enable_reg <= 1'b0;
			overflow_flag_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			irq_enable_reg <= irq_enable_next;
			overflow_flag_reg <= overflow_flag_next;
			wake_reg <= wake_next;
		end
	end

	// Read data captured in setup so it comes from a flop in the access phase
	always_comb begin
		prdata_next = prdata_reg;
		if (setup_ph & ~apb_req_i.pwrite) begin
			prdata_next = 32'h0000_0000;
			if (addr_hit(apb_req_i.paddr, `TEC_ADDR_LOW)) begin
				prdata_next[7:0] = byte_buf_reg;
			end else if (addr_hit(apb_req_i.paddr, `TEC_ADDR_HIGH)) begin
				prdata_next[7:0] = count_reg[15:8];
			end else if (addr_hit(apb_req_i.paddr, `TEC_ADDR_CTRL)) begin
				// Bits 2:0 and 5 stay zero
				prdata_next[`TEC_CTRL_MODE_HI:`TEC_CTRL_MODE_LO] = mode_reg;
				prdata_next[`TEC_CTRL_RUN] = count_run_reg;
				prdata_next[`TEC_CTRL_EDGE] = edge_select_reg;
			end else if (addr_hit(apb_req_i.paddr, `TEC_ADDR_INTERRUPT_CONTROL)) begin
				prdata_next[`TEC_INTERRUPT_CONTROL_FLAG] = overflow_flag_reg;
				prdata_next[`TEC_INTERRUPT_CONTROL_IRQ_EN] = irq_enable_reg;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prdata_reg <= 32'h0000_0000;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	always_comb begin
		apb_rsp_o.prdata = prdata_reg;
		apb_rsp_o.pready = 1'b1;
		apb_rsp_o.pslverr = access_ph & ~mapped;
	end

	assign overflow_irq_o = overflow_flag_reg & irq_enable_reg;
	assign overflow_flag_o = overflow_flag_reg;
	assign wake_o = wake_reg;

	// Checks
	sequence meas_end_s;
		(state_reg == TEC_ST_MEAS) && pin_ev.ret && count_run_reg && !wr_ctrl
			&& (mode_reg == TEC_MODE_PULSE);
	endsequence

	sequence meas_start_s;
		(state_reg == TEC_ST_WAIT) && (mode_reg == TEC_MODE_PULSE) && count_run_reg
			&& pin_ev.active && !wr_ctrl;
	endsequence

	count_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && !overflow && !wr_high |=> count_reg == $past(count_reg) + 16'h0001)
		else $error("counter did not step by one");

	reload_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		overflow && !wr_high |=> count_reg == $past(preload_reg) && overflow_flag_reg)
		else $error("overflow did not reload and flag");

	ctrl_zero_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		setup_ph && !apb_req_i.pwrite && addr_hit(apb_req_i.paddr, `TEC_ADDR_CTRL)
		|=> prdata_reg[2:0] == 3'h0 && !prdata_reg[5])
		else $error("unused control bits not zero");

	rise_counts_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(counter_input_pin_i) && !edge_select_reg && count_run_reg
		&& mode_reg == TEC_MODE_EVENT && !count_block && !wr_high
		&& count_reg != `TEC_CNT_MAX |=> count_reg == $past(count_reg) + 16'h0001)
		else $error("rising edge not counted");

	stopped_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!count_run_reg && !wr_high |=> $stable(count_reg))
		else $error("counter moved while stopped");

	pulse_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
		meas_end_s |=> !count_run_reg ##0 state_reg == TEC_ST_WAIT
		##1 (!count_run_reg || $past(wr_ctrl)))
		else $error("pulse end did not stop and clear run");

	pulse_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		meas_start_s |=> state_reg == TEC_ST_MEAS)
		else $error("edge did not start measurement");

	level_no_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_reg == TEC_ST_WAIT && !pin_ev.active |=> state_reg == TEC_ST_WAIT)
		else $error("measurement started without edge");

	run_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
		count_run_reg && mode_reg != TEC_MODE_PULSE && !wr_ctrl |=> count_run_reg)
		else $error("run bit cleared by hardware");

	wake_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		overflow |=> wake_o ##1 (wake_o == $past(overflow)))
		else $error("overflow gave no wake pulse");

	irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		overflow && !irq_enable_reg && !wr_interrupt_control |=> !overflow_irq_o && overflow_flag_reg)
		else $error("masked overflow reached interrupt");

	load_stopped_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_high && !count_run_reg |=> count_reg == $past(wr_value))
		else $error("stopped preload write not copied");

	read_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		count_block |=> $stable(count_reg))
		else $error("counter moved during high byte read");

	ret_no_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
		meas_end_s && !wr_high |=> $stable(count_reg))
		else $error("return cycle of pulse was counted");

endmodule

// file: tec_pin_model.sv
// External pin model: sends a train of pulses around a chosen idle level
`timescale 1ns/1ns
module tec_pin_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pulse train request
	input wire logic go_i,
	input wire logic idle_i,
	input wire logic [7:0] width_i,
	input wire logic [3:0] count_i,
	// Pin and status
	output logic pin_o,
	output logic busy_o
);
	logic [3:0] left_reg;
	logic [7:0] len_reg;
	logic act_reg;

	// Each level lasts width_i cycles, so high and low spans are exact
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left_reg <= 4'h0;
			len_reg <= 8'h00;
			act_reg <= 1'b0;
		end else if (go_i) begin
			left_reg <= count_i;
			len_reg <= width_i;
			act_reg <= 1'b1;
		end else if (left_reg != 4'h0) begin
			if (len_reg == 8'h01) begin
				len_reg <= width_i;
				act_reg <= !act_reg;
				if (act_reg)
					left_reg <= left_reg - 4'h1;
			end else
				len_reg <= len_reg - 8'h01;
		end
	end

	assign busy_o = (left_reg != 4'h0);
	assign pin_o = (busy_o && act_reg) ? !idle_i : idle_i;
endmodule

// file: tec_top_bench.sv
// Self-checking bench of the timer/event counter
`timescale 1ns/1ns
`include "tec_cfg.svh"
module tec_top_bench;
	import tec_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	tec_apb_req_type req = '0;
	tec_apb_rsp_type rsp;
	logic pin, irq, flag, wake, busy, go = 1'b0, last_err;
	logic [7:0] width = 8'h02;
	logic [3:0] cnt = 4'h1;
	logic idle = 1'b0;
	int error_cnt = 0;
	int n_compared = 0;

	tec_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .apb_req_i(req), .apb_rsp_o(rsp),
		.counter_input_pin_i(pin), .overflow_irq_o(irq), .overflow_flag_o(flag),
		.wake_o(wake));
	tec_pin_model i_pin (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .idle_i(idle),
		.width_i(width), .count_i(cnt), .pin_o(pin), .busy_o(busy));

	initial begin
		forever #25 clk_i = !clk_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("errors=%0d compared=%0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Holds the request until pready is seen high, data taken at that edge
	task automatic apb(input logic is_wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		req.psel <= 1'b1;
		req.pwrite <= is_wr;
		req.paddr <= a;
		req.pwdata <= {24'h0, d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do @(posedge clk_i); while (rsp.pready !== 1'b1);
		q = rsp.prdata[7:0];
		last_err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		apb(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask

	task automatic wr16(input logic [15:0] v);
		wr(`TEC_ADDR_LOW, v[7:0]);
		wr(`TEC_ADDR_HIGH, v[15:8]);
	endtask

	task automatic rd16_chk(input logic [15:0] exp);
		rd_chk(`TEC_ADDR_HIGH, exp[15:8]);
		rd_chk(`TEC_ADDR_LOW, exp[7:0]);
	endtask

	task automatic send(input logic [7:0] w, input logic [3:0] n);
		int i;
		width <= w;
		cnt <= n;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
		for (i = 0; i < 200 && busy === 1'b1; i++)
			@(posedge clk_i);
	endtask

	task automatic t_reset();
		rd_chk(`TEC_ADDR_CTRL, `TEC_CTRL_RESET);
		rd_chk(`TEC_ADDR_INTERRUPT_CONTROL, `TEC_INTERRUPT_CONTROL_RESET);
		wr(`TEC_ADDR_CTRL, 8'hff);
		rd_chk(`TEC_ADDR_CTRL, 8'hd8);
		wr(`TEC_ADDR_CTRL, 8'h08);
	endtask

	task automatic t_preload();
		wr16(16'h1234);
		rd16_chk(16'h1234);
	endtask

	// Run is set for exactly the three edges between the two writes
	task automatic t_timer();
		wr16(16'h0000);
		wr(`TEC_ADDR_CTRL, 8'h90);
		wr(`TEC_ADDR_CTRL, 8'h80);
		rd16_chk(16'h0003);
		send(8'h02, 4'h2);
		rd16_chk(16'h0003);
		wr(`TEC_ADDR_CTRL, 8'h00);
		wr(`TEC_ADDR_CTRL, 8'h10);
		wr(`TEC_ADDR_CTRL, 8'h08);
		rd16_chk(16'h0003);
	endtask

	task automatic t_event();
		wr16(16'h0000);
		wr(`TEC_ADDR_CTRL, 8'h50);
		send(8'h02, 4'h3);
		wr(`TEC_ADDR_CTRL, 8'h40);
		rd16_chk(16'h0003);
		wr(`TEC_ADDR_CTRL, 8'h58);
		send(8'h03, 4'h2);
		wr(`TEC_ADDR_CTRL, 8'h48);
		rd16_chk(16'h0005);
	endtask

	task automatic t_overflow();
		int i;
		int w;
		wr16(16'hfffe);
		wr(`TEC_ADDR_INTERRUPT_CONTROL, 8'h00);
		wr(`TEC_ADDR_CTRL, 8'h90);
		for (i = 0; i < 20 && flag !== 1'b1; i++)
			@(posedge clk_i);
		chk(flag, 1'b1);
		w = 0;
		for (i = 0; i < 3; i++) begin
			#1;
			if (wake === 1'b1)
				w++;
			@(posedge clk_i);
		end
		chk(w, 1);
		chk(irq, 1'b0);
		wr(`TEC_ADDR_INTERRUPT_CONTROL, 8'h24);
		#1;
		chk(irq, 1'b1);
		rd_chk(`TEC_ADDR_CTRL, 8'h90);
		wr(`TEC_ADDR_CTRL, 8'h80);
		wr(`TEC_ADDR_INTERRUPT_CONTROL, 8'h04);
		#1;
		chk({flag, irq}, 2'b00);
		wr(`TEC_ADDR_INTERRUPT_CONTROL, 8'h00);
	endtask

	// Preload written while running: counter untouched until the wrap
	task automatic t_running_load();
		wr16(16'hffff);
		wr(`TEC_ADDR_CTRL, 8'h50);
		wr16(16'h0042);
		rd16_chk(16'hffff);
		send(8'h02, 4'h1);
		rd16_chk(16'h0042);
		chk(flag, 1'b1);
		wr(`TEC_ADDR_CTRL, 8'h08);
		wr(`TEC_ADDR_INTERRUPT_CONTROL, 8'h00);
	endtask

	// High for five cycles: first cycle only arms, four are counted
	task automatic t_pulse();
		wr16(16'h0000);
		wr(`TEC_ADDR_CTRL, 8'hd0);
		send(8'h05, 4'h1);
		rd_chk(`TEC_ADDR_CTRL, 8'hc0);
		rd16_chk(16'h0004);
		send(8'h05, 4'h1);
		rd16_chk(16'h0004);
		// Four counts from fffe wrap twice with preload fffe
		wr16(16'hfffe);
		wr(`TEC_ADDR_CTRL, 8'hd0);
		chk(flag, 1'b0);
		send(8'h05, 4'h1);
		chk(flag, 1'b1);
		rd16_chk(16'hfffe);
		wr(`TEC_ADDR_INTERRUPT_CONTROL, 8'h00);
		// Idle high, low for four cycles: falling start, three counted
		wr(`TEC_ADDR_CTRL, 8'h08);
		idle <= 1'b1;
		wr16(16'h0000);
		wr(`TEC_ADDR_CTRL, 8'hd8);
		send(8'h04, 4'h1);
		rd_chk(`TEC_ADDR_CTRL, 8'hc8);
		rd16_chk(16'h0003);
		wr(`TEC_ADDR_CTRL, 8'h08);
		idle <= 1'b0;
	endtask

	task automatic t_unmapped();
		wr(8'h10, 8'h5a);
		rd_chk(8'h10, 8'h00);
		chk(last_err, 1'b1);
	endtask

	initial begin
		#300000;
		error_cnt++;
		results();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_preload();
		t_timer();
		t_event();
		t_overflow();
		t_running_load();
		t_pulse();
		t_unmapped();
		results();
	end
endmodule
